// file: hdl/ipc_device_end.sv
// Device end of the pixel entry link: mode register, pixel counter and store stream.
//
// Summary of operation
// - Mode zero is normal; no pixel transfers taken.
// - Host writes zero before selecting code 011.
// - Code 001 converts YUV pixels to RGB; this device only stores words tagged 001, arithmetic is downstream.
// - Code 010 converts delta-YUV pixels to RGB; this device only stores words tagged 010, arithmetic is downstream.
// - Code 011 stores 16-bit pixels unchanged.
// - Host writes 100 before 111; never 101/110.
// - Code 111 stores 8-bit pixels unchanged.
// - Count reaching zero clears mode to normal.
// - Total count is width times height.
// - Count drops by one per processed pixel.
// - For 8-bit mode width counts words.
// - Host avoids memory chip select while active.
// - Reset clears the mode register to zero.
// - Host should not change mode mid-conversion.
`timescale 1ns/1ps
module ipc_device_end (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	ipc_link_if.device link,
	output logic store_valid_out,
	output logic [ipc_pkg::PIX_W-1:0] store_data_out,
	output logic [ipc_pkg::MODE_W-1:0] store_fmt_out,
	output logic conv_active_out,
	output logic [ipc_pkg::COUNT_W-1:0] pixels_left_out,
	output logic cs_conflict_out,
	output logic bad_mode_out,
	output logic mode_cleared_out
);

	////////////////////////////////////////////////////////////////////////////////
	logic [ipc_pkg::MODE_W-1:0] mode_ff;
	logic [ipc_pkg::MODE_W-1:0] nxt_mode;
	logic ready_ff;
	logic nxt_ready;
	logic [ipc_pkg::HSIZE_W-1:0] hsize_ff;
	logic [ipc_pkg::HSIZE_W-1:0] nxt_hsize;
	logic [ipc_pkg::VSIZE_W-1:0] vsize_ff;
	logic [ipc_pkg::VSIZE_W-1:0] nxt_vsize;
	logic store_valid_ff;
	logic nxt_store_valid;
	logic [ipc_pkg::PIX_W-1:0] store_data_ff;
	logic [ipc_pkg::PIX_W-1:0] nxt_store_data;
	logic [ipc_pkg::MODE_W-1:0] store_fmt_ff;
	logic [ipc_pkg::MODE_W-1:0] nxt_store_fmt;
	logic cs_conflict_ff;
	logic nxt_cs_conflict;
	logic bad_mode_ff;
	logic nxt_bad_mode;
	logic cleared_ff;
	logic nxt_cleared;
	logic accept;
	logic last_pixel;
	logic load;
	logic [ipc_pkg::COUNT_W-1:0] count;
	logic [ipc_pkg::COUNT_W-1:0] total;

	////////////////////////////////////////////////////////////////////////////////
	// Size values are latched so the product is stable when the mode write loads it.
	always_comb begin
		nxt_hsize = hsize_ff;
		nxt_vsize = vsize_ff;
		if (link.size_wr) begin
			nxt_hsize = link.hsize;
			nxt_vsize = link.vsize;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			hsize_ff <= ipc_pkg::HSIZE_RST;
			vsize_ff <= ipc_pkg::VSIZE_RST;
		end else begin
			hsize_ff <= nxt_hsize;
			vsize_ff <= nxt_vsize;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pixels are only taken while ready, and ready exists only in an active mode.
	assign accept = link.pix_wr && ready_ff;
	assign last_pixel = accept && (count == ipc_pkg::COUNT_ONE);
	assign load = link.mode_wr && ipc_pkg::ipc_is_active(link.mode_wdata);
	assign total = ipc_pkg::ipc_total(hsize_ff, vsize_ff);

	ipc_pix_counter u_counter (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.load_in(load),
		.dec_in(accept),
		.hsize_in(hsize_ff),
		.vsize_in(vsize_ff),
		.count_out(count)
	);

	////////////////////////////////////////////////////////////////////////////////
	// An active-code mode write mid-conversion restarts the count; any other code drops ready and keeps the count; the host is told to avoid it.
	// Zero size ends the run at once, since no pixel would ever bring the count down to zero.
	// Ready falls in the same cycle as the mode, so no word can slip in after the last one.
	always_comb begin
		nxt_mode = mode_ff;
		nxt_ready = ready_ff;
		nxt_cleared = 1'b0;
		if (link.mode_wr) begin
			nxt_mode = link.mode_wdata;
			nxt_ready = load;
			if (load && (total == ipc_pkg::COUNT_RST)) begin
				nxt_mode = ipc_pkg::MODE_NORMAL;
				nxt_ready = 1'b0;
				nxt_cleared = 1'b1;
			end
		end else if (last_pixel) begin
			nxt_mode = ipc_pkg::MODE_NORMAL;
			nxt_ready = 1'b0;
			nxt_cleared = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			mode_ff <= ipc_pkg::MODE_RST;
			ready_ff <= 1'b0;
			cleared_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			ready_ff <= nxt_ready;
			cleared_ff <= nxt_cleared;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// The colour arithmetic lives downstream; this stage tags each word with its format.
	// Each word keeps the mode it was taken in, so a later mode write cannot retag it.
	always_comb begin
		nxt_store_valid = accept;
		nxt_store_data = store_data_ff;
		nxt_store_fmt = store_fmt_ff;
		if (accept) begin
			nxt_store_data = link.pix_data;
			unique case (mode_ff)
				ipc_pkg::MODE_YUV: nxt_store_fmt = ipc_pkg::MODE_YUV;
				ipc_pkg::MODE_DYUV: nxt_store_fmt = ipc_pkg::MODE_DYUV;
				ipc_pkg::MODE_PASS16: nxt_store_fmt = ipc_pkg::MODE_PASS16;
				ipc_pkg::MODE_PASS8: nxt_store_fmt = ipc_pkg::MODE_PASS8;
				default: nxt_store_fmt = ipc_pkg::MODE_NORMAL;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			store_valid_ff <= 1'b0;
			store_data_ff <= ipc_pkg::PIX_RST;
			store_fmt_ff <= ipc_pkg::MODE_RST;
		end else begin
			store_valid_ff <= nxt_store_valid;
			store_data_ff <= nxt_store_data;
			store_fmt_ff <= nxt_store_fmt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sticky diagnostics for host misuse; they only clear at reset since there is no register bus.
	// A forbidden code is still written into the register; the flag only reports the broken sequence.
	// A memory select is not blocked in an active mode, because the pin belongs to the host.
	always_comb begin
		nxt_cs_conflict = cs_conflict_ff;
		nxt_bad_mode = bad_mode_ff;
		if (link.vgm_cs && (mode_ff != ipc_pkg::MODE_NORMAL)) begin
			nxt_cs_conflict = 1'b1;
		end
		if (link.mode_wr && ((link.mode_wdata == ipc_pkg::MODE_BAD5) || (link.mode_wdata == ipc_pkg::MODE_BAD6))) begin
			nxt_bad_mode = 1'b1;
		end
		if (link.mode_wr && (link.mode_wdata == ipc_pkg::MODE_PASS16) && (mode_ff != ipc_pkg::MODE_NORMAL)) begin
			nxt_bad_mode = 1'b1;
		end
		if (link.mode_wr && (link.mode_wdata == ipc_pkg::MODE_PASS8) && (mode_ff != ipc_pkg::MODE_PRE8)) begin
			nxt_bad_mode = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cs_conflict_ff <= 1'b0;
			bad_mode_ff <= 1'b0;
		end else begin
			cs_conflict_ff <= nxt_cs_conflict;
			bad_mode_ff <= nxt_bad_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign link.mode_rd = mode_ff;
	assign link.pix_ready = ready_ff;
	assign store_valid_out = store_valid_ff;
	assign store_data_out = store_data_ff;
	assign store_fmt_out = store_fmt_ff;
	assign conv_active_out = ready_ff;
	assign pixels_left_out = count;
	assign cs_conflict_out = cs_conflict_ff;
	assign bad_mode_out = bad_mode_ff;
	assign mode_cleared_out = cleared_ff;

endmodule : ipc_device_end

// file: hdl/ipc_pkg.sv
// Shared constants, mode codes and helper functions for the input pixel conversion block.
package ipc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	localparam int MODE_W = 3;
	localparam int HSIZE_W = 10;
	localparam int VSIZE_W = 10;
	localparam int COUNT_W = HSIZE_W + VSIZE_W;
	localparam int PIX_W = 16;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [MODE_W-1:0] MODE_NORMAL = 3'h0;
	localparam logic [MODE_W-1:0] MODE_YUV = 3'h1;
	localparam logic [MODE_W-1:0] MODE_DYUV = 3'h2;
	localparam logic [MODE_W-1:0] MODE_PASS16 = 3'h3;
	localparam logic [MODE_W-1:0] MODE_PRE8 = 3'h4;
	localparam logic [MODE_W-1:0] MODE_BAD5 = 3'h5;
	localparam logic [MODE_W-1:0] MODE_BAD6 = 3'h6;
	localparam logic [MODE_W-1:0] MODE_PASS8 = 3'h7;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
	localparam logic [COUNT_W-1:0] COUNT_RST = 20'h00000;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 20'h00001;
	localparam logic [PIX_W-1:0] PIX_RST = 16'h0000;
	localparam logic [HSIZE_W-1:0] HSIZE_RST = 10'h000;
	localparam logic [VSIZE_W-1:0] VSIZE_RST = 10'h000;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic ipc_is_active(input logic [MODE_W-1:0] mode);
		ipc_is_active = (mode == MODE_YUV) || (mode == MODE_DYUV) || (mode == MODE_PASS16) || (mode == MODE_PASS8);
	endfunction : ipc_is_active

	function automatic logic [MODE_W-1:0] ipc_pre_code(input logic [MODE_W-1:0] mode);
		ipc_pre_code = (mode == MODE_PASS8) ? MODE_PRE8 : MODE_NORMAL;
	endfunction : ipc_pre_code

	function automatic logic [COUNT_W-1:0] ipc_total(input logic [HSIZE_W-1:0] h, input logic [VSIZE_W-1:0] v);
		ipc_total = COUNT_W'(h) * COUNT_W'(v);
	endfunction : ipc_total

endpackage : ipc_pkg

// file: hdl/ipc_link_if.sv
// Interface joining the host end and the device end of the pixel entry link.
`timescale 1ns/1ps
interface ipc_link_if;
	logic mode_wr;
	logic [2:0] mode_wdata;
	logic [2:0] mode_rd;
	logic size_wr;
	logic [9:0] hsize;
	logic [9:0] vsize;
	logic pix_wr;
	logic [15:0] pix_data;
	logic pix_ready;
	logic vgm_cs;

	modport device (
		input mode_wr,
		input mode_wdata,
		output mode_rd,
		input size_wr,
		input hsize,
		input vsize,
		input pix_wr,
		input pix_data,
		output pix_ready,
		input vgm_cs
	);

	modport host (
		output mode_wr,
		output mode_wdata,
		input mode_rd,
		output size_wr,
		output hsize,
		output vsize,
		output pix_wr,
		output pix_data,
		input pix_ready,
		output vgm_cs
	);
endinterface : ipc_link_if

// file: hdl/ipc_pix_counter.sv
// Remaining pixel counter: loads width times height and counts down per processed pixel.
`timescale 1ns/1ps
module ipc_pix_counter (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic load_in,
	input wire logic dec_in,
	input wire logic [ipc_pkg::HSIZE_W-1:0] hsize_in,
	input wire logic [ipc_pkg::VSIZE_W-1:0] vsize_in,
	output logic [ipc_pkg::COUNT_W-1:0] count_out
);
	logic [ipc_pkg::COUNT_W-1:0] count_ff;
	logic [ipc_pkg::COUNT_W-1:0] nxt_count;

	always_comb begin
		nxt_count = count_ff;
		if (load_in) begin
			nxt_count = ipc_pkg::ipc_total(hsize_in, vsize_in);
		end else if (dec_in && (count_ff != ipc_pkg::COUNT_RST)) begin
			nxt_count = count_ff - ipc_pkg::COUNT_ONE;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			count_ff <= ipc_pkg::COUNT_RST;
		end else begin
			count_ff <= nxt_count;
		end
	end

	assign count_out = count_ff;
endmodule : ipc_pix_counter

// file: hdl/ipc_host_end.sv
// Host end of the pixel entry link: mode write sequencing and pixel feeding.
`timescale 1ns/1ps
module ipc_host_end (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	ipc_link_if.host link,
	input wire logic start_in,
	input wire logic [ipc_pkg::MODE_W-1:0] mode_in,
	input wire logic [ipc_pkg::HSIZE_W-1:0] hsize_in,
	input wire logic [ipc_pkg::VSIZE_W-1:0] vsize_in,
	input wire logic px_valid_in,
	input wire logic [ipc_pkg::PIX_W-1:0] px_data_in,
	output logic px_ready_out,
	input wire logic vgm_req_in,
	output logic busy_out,
	output logic done_out
);
	typedef enum logic [2:0] {
		IDLE = 3'h0,
		SIZE = 3'h1,
		PRE = 3'h2,
		MODE = 3'h3,
		SEND = 3'h4
	} ipc_host_state_e;

	ipc_host_state_e state_ff, nxt_state;
	logic [ipc_pkg::MODE_W-1:0] target_ff, nxt_target;
	logic mode_wr_ff, nxt_mode_wr;
	logic [ipc_pkg::MODE_W-1:0] mode_wdata_ff, nxt_mode_wdata;
	logic size_wr_ff, nxt_size_wr;
	logic [ipc_pkg::HSIZE_W-1:0] hsize_ff, nxt_hsize;
	logic [ipc_pkg::VSIZE_W-1:0] vsize_ff, nxt_vsize;
	logic hold_ff, nxt_hold;
	logic [ipc_pkg::PIX_W-1:0] pix_ff, nxt_pix;
	logic px_ready_ff, nxt_px_ready;
	logic vgm_cs_ff, nxt_vgm_cs;
	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;

	////////////////////////////////////////////////////////////////////////////////
	// One word is held at a time, so the stream runs at half rate; simplicity over throughput.
	always_comb begin
		nxt_state = state_ff;
		nxt_target = target_ff;
		nxt_mode_wr = 1'b0;
		nxt_mode_wdata = mode_wdata_ff;
		nxt_size_wr = 1'b0;
		nxt_hsize = hsize_ff;
		nxt_vsize = vsize_ff;
		nxt_hold = hold_ff;
		nxt_pix = pix_ff;
		nxt_done = 1'b0;
		if (hold_ff && link.pix_ready) begin
			nxt_hold = 1'b0;
		end
		unique case (state_ff)
			IDLE: if (start_in && ipc_pkg::ipc_is_active(mode_in)) begin
				nxt_state = SIZE;
				nxt_target = mode_in;
				nxt_size_wr = 1'b1;
				nxt_hsize = hsize_in;
				nxt_vsize = vsize_in;
			end
			SIZE: begin
				nxt_state = PRE;
				nxt_mode_wr = 1'b1;
				nxt_mode_wdata = ipc_pkg::ipc_pre_code(target_ff);
			end
			PRE: begin
				nxt_state = MODE;
				nxt_mode_wr = 1'b1;
				nxt_mode_wdata = target_ff;
			end
			MODE: nxt_state = SEND;
			SEND: begin
				if (px_ready_ff && px_valid_in) begin
					nxt_hold = 1'b1;
					nxt_pix = px_data_in;
				end
				if (link.mode_rd == ipc_pkg::MODE_NORMAL) begin
					nxt_state = IDLE;
					nxt_hold = 1'b0;
					nxt_done = 1'b1;
				end
			end
			default: nxt_state = IDLE;
		endcase
		nxt_px_ready = (nxt_state == SEND) && !nxt_hold;
		nxt_busy = nxt_state != IDLE;
		nxt_vgm_cs = vgm_req_in && !nxt_busy && (state_ff == IDLE);
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff <= IDLE;
			target_ff <= ipc_pkg::MODE_RST;
			mode_wr_ff <= 1'b0;
			mode_wdata_ff <= ipc_pkg::MODE_RST;
			size_wr_ff <= 1'b0;
			hsize_ff <= ipc_pkg::HSIZE_RST;
			vsize_ff <= ipc_pkg::VSIZE_RST;
			hold_ff <= 1'b0;
			pix_ff <= ipc_pkg::PIX_RST;
			px_ready_ff <= 1'b0;
			vgm_cs_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			target_ff <= nxt_target;
			mode_wr_ff <= nxt_mode_wr;
			mode_wdata_ff <= nxt_mode_wdata;
			size_wr_ff <= nxt_size_wr;
			hsize_ff <= nxt_hsize;
			vsize_ff <= nxt_vsize;
			hold_ff <= nxt_hold;
			pix_ff <= nxt_pix;
			px_ready_ff <= nxt_px_ready;
			vgm_cs_ff <= nxt_vgm_cs;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign link.mode_wr = mode_wr_ff;
	assign link.mode_wdata = mode_wdata_ff;
	assign link.size_wr = size_wr_ff;
	assign link.hsize = hsize_ff;
	assign link.vsize = vsize_ff;
	assign link.pix_wr = hold_ff;
	assign link.pix_data = pix_ff;
	assign link.vgm_cs = vgm_cs_ff;
	assign px_ready_out = px_ready_ff;
	assign busy_out = busy_ff;
	assign done_out = done_ff;

endmodule : ipc_host_end

// file: test/ipc_link_properties.sv
// Assertions on the pixel entry link between the host end and the device end.
`timescale 1ns/1ps
module ipc_link_properties (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic mode_wr,
	input wire logic [2:0] mode_wdata,
	input wire logic [2:0] mode_rd,
	input wire logic size_wr,
	input wire logic [9:0] hsize,
	input wire logic [9:0] vsize,
	input wire logic pix_wr,
	input wire logic [15:0] pix_data,
	input wire logic pix_ready,
	input wire logic vgm_cs
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////
	// Shadow count rebuilt from the link alone; every active mode write reloads it, mid-run or not, as the device counter does.
	logic [19:0] prod_ff;
	logic [19:0] nxt_prod;
	logic [19:0] left_ff;
	logic [19:0] nxt_left;
	logic act_wr;
	logic take;
	always_comb begin
		act_wr = mode_wr && (mode_wdata inside {3'h1, 3'h2, 3'h3, 3'h7});
		take = pix_wr && pix_ready;
		nxt_prod = size_wr ? {10'h000, hsize} * {10'h000, vsize} : prod_ff;
		nxt_left = left_ff;
		if (act_wr) begin
			nxt_left = prod_ff;
		end else if (take && left_ff != 20'h00000) begin
			nxt_left = left_ff - 20'h00001;
		end
	end
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			prod_ff <= 20'h00000;
			left_ff <= 20'h00000;
		end else begin
			prod_ff <= nxt_prod;
			left_ff <= nxt_left;
		end
	end
	////////////////////////////////////////
	AST_READY_MODE: assert property (pix_ready |-> mode_rd inside {3'h1, 3'h2, 3'h3, 3'h7})
		else $error("ready outside an active mode");
	AST_PLAIN_WRITE: assert property (mode_wr && mode_wdata inside {3'h0, 3'h4} |=>
		mode_rd == $past(mode_wdata) && !pix_ready) else $error("plain mode write wrong");
	AST_ACTIVE_WRITE: assert property (act_wr && prod_ff != 20'h00000 |=>
		mode_rd == $past(mode_wdata) && pix_ready) else $error("active mode not entered");
	AST_ZERO_SIZE: assert property (act_wr && prod_ff == 20'h00000 |=> mode_rd == 3'h0)
		else $error("zero size did not clear mode");
	AST_LAST_PIXEL: assert property (take && left_ff == 20'h00001 |=> mode_rd == 3'h0 && !pix_ready)
		else $error("mode not cleared after last pixel");
	AST_COUNT_ON: assert property (take && left_ff > 20'h00001 && !mode_wr |=> $stable(mode_rd) && pix_ready)
		else $error("run ended early");
	AST_READY_STANDS: assert property (pix_ready && !take && !mode_wr |=> pix_ready)
		else $error("ready dropped without transfer");
	AST_READY_QUIET: assert property (!pix_ready && !mode_wr |=> !pix_ready)
		else $error("ready rose without mode write");
	AST_RESET_NORMAL: assert property ($fell(rst_in) |-> mode_rd == 3'h0 && !pix_ready)
		else $error("mode not normal after reset");
	AST_PASS16_ORDER: assert property (mode_wr && mode_wdata == 3'h3 |-> mode_rd == 3'h0)
		else $error("code 3 not written from normal");
	AST_PASS8_ORDER: assert property (mode_wr && mode_wdata inside {3'h5, 3'h6, 3'h7} |->
		mode_wdata == 3'h7 && mode_rd == 3'h4) else $error("bad code or code 7 order");
	AST_CS_QUIET: assert property (mode_rd != 3'h0 |-> !vgm_cs)
		else $error("memory select during active mode");
	AST_SIZE_FIRST: assert property (act_wr |-> $past(size_wr, 2))
		else $error("size not written before mode");
	cover property (take && left_ff == 20'h00001 ##1 mode_rd == 3'h0);
	cover property (act_wr && prod_ff == 20'h00000);
	cover property (mode_wr && mode_wdata == 3'h7);
	cover property (take ##1 take);
endmodule : ipc_link_properties

// file: test/tb_top.sv
// Self-checking bench for the host end and the device end of the pixel entry link.
`timescale 1ns/1ps
module tb_top;
	logic clk_sys_in;
	logic rst_in;
	logic start_in;
	logic [2:0] mode_in;
	logic [9:0] hsize_in;
	logic [9:0] vsize_in;
	logic px_valid_in;
	logic [15:0] px_data_in;
	logic vgm_req_in;
	logic px_ready_out, busy_out, done_out, sv, ca, bm, csc, mc, sv2, ca2, bm2, csc2;
	logic [15:0] sd;
	logic [2:0] sf;
	logic [19:0] pl;
	logic [2:0] cur_mode;
	logic [15:0] expq [$];
	logic [2:0] modes [4] = '{ipc_pkg::MODE_YUV, ipc_pkg::MODE_DYUV, ipc_pkg::MODE_PASS16, ipc_pkg::MODE_PASS8};
	int n_mismatch = 0;
	int check_count = 0;
	int seed = 50016;
	int n_store = 0;
	int n_store2 = 0;
	int n_clr = 0;
	int n_feed = 0;
	ipc_link_if link();
	ipc_link_if link2();
	ipc_host_end ipc_host_end_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link), .start_in(start_in),
		.mode_in(mode_in), .hsize_in(hsize_in), .vsize_in(vsize_in), .px_valid_in(px_valid_in),
		.px_data_in(px_data_in), .px_ready_out(px_ready_out), .vgm_req_in(vgm_req_in), .busy_out(busy_out),
		.done_out(done_out));
	ipc_device_end ipc_device_end_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link), .store_valid_out(sv),
		.store_data_out(sd), .store_fmt_out(sf), .conv_active_out(ca), .pixels_left_out(pl),
		.cs_conflict_out(csc), .bad_mode_out(bm), .mode_cleared_out(mc));
	// Second device faces the bench, which breaks the host ordering on purpose.
	ipc_device_end ipc_device_end_i2 (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link2),
		.store_valid_out(sv2), .store_data_out(), .store_fmt_out(), .conv_active_out(ca2), .pixels_left_out(),
		.cs_conflict_out(csc2), .bad_mode_out(bm2), .mode_cleared_out());
	ipc_link_properties ipc_link_properties_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.mode_wr(link.mode_wr), .mode_wdata(link.mode_wdata), .mode_rd(link.mode_rd), .size_wr(link.size_wr),
		.hsize(link.hsize), .vsize(link.vsize), .pix_wr(link.pix_wr), .pix_data(link.pix_data),
		.pix_ready(link.pix_ready), .vgm_cs(link.vgm_cs));
	////////////////////////////////////////
	function automatic int exp_words(input logic [9:0] h, input logic [9:0] v);
		return int'(h) * int'(v);
	endfunction : exp_words
	task automatic check(input logic ok, input string msg);
		check_count++;
		if (!ok) begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict
	task automatic start(input logic [2:0] m, input logic [9:0] h, input logic [9:0] v);
		@(posedge clk_sys_in);
		start_in <= 1'b1;
		mode_in <= m;
		hsize_in <= h;
		vsize_in <= v;
		@(posedge clk_sys_in);
		start_in <= 1'b0;
	endtask : start
	task automatic run(input logic [2:0] m, input logic [9:0] h, input logic [9:0] v);
		int k;
		int b;
		n_store = 0;
		n_clr = 0;
		cur_mode = m;
		n_feed = exp_words(h, v);
		expq.delete();
		start(m, h, v);
		k = 0;
		b = 0;
		while (done_out !== 1'b1 && k < 3000) begin
			@(negedge clk_sys_in);
			if (busy_out === 1'b1) b++;
			k++;
		end
		check(k < 3000, "run never finished");
		check(b > 0 && busy_out === 1'b0 && ca === 1'b0 && px_ready_out === 1'b0, "busy state wrong");
		check(n_store == exp_words(h, v), "stored word count");
		check(n_clr == 1 && link.mode_rd === ipc_pkg::MODE_NORMAL, "mode not cleared once");
		check(pl === ipc_pkg::COUNT_RST && expq.size() == 0, "count or words left over");
	endtask : run
	task automatic wr2(input logic [2:0] code, input logic cs);
		@(posedge clk_sys_in);
		link2.mode_wr <= 1'b1;
		link2.mode_wdata <= code;
		@(posedge clk_sys_in);
		link2.mode_wr <= 1'b0;
		link2.vgm_cs <= cs;
		@(posedge clk_sys_in);
		link2.vgm_cs <= 1'b0;
		repeat (2) @(negedge clk_sys_in);
	endtask : wr2
	////////////////////////////////////////
	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) begin
		// The user side offers exactly one run's worth of words, so none is left hanging at the end.
		if (!rst_in && px_valid_in && px_ready_out) begin
			expq.push_back(px_data_in);
			n_feed--;
		end
		if (!px_valid_in || px_ready_out) begin
			px_valid_in <= (n_feed > 0) && (($random(seed) % 4) != 0);
			px_data_in <= 16'($random(seed));
		end
		vgm_req_in <= 1'($random(seed));
		if (!rst_in && mc) n_clr++;
		if (!rst_in && sv2) n_store2++;
		if (!rst_in && sv) begin
			n_store++;
			check(expq.size() > 0 && sd === expq[0] && sf === cur_mode, "stored word");
			if (expq.size() > 0) void'(expq.pop_front());
		end
	end
	initial begin
		repeat (40000) @(posedge clk_sys_in);
		n_mismatch++;
		$display("mismatch at %0t: watchdog expired", $time);
		give_verdict();
	end
	initial begin
		rst_in = 1'b1;
		start_in = 1'b0;
		mode_in = 3'h0;
		hsize_in = 10'h000;
		vsize_in = 10'h000;
		px_valid_in = 1'b0;
		px_data_in = 16'h0000;
		vgm_req_in = 1'b0;
		link2.mode_wr = 1'b0;
		link2.mode_wdata = 3'h0;
		link2.size_wr = 1'b0;
		link2.hsize = 10'h002;
		link2.vsize = 10'h001;
		link2.pix_wr = 1'b1;
		link2.pix_data = 16'h00a5;
		link2.vgm_cs = 1'b0;
		repeat (16) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		run(ipc_pkg::MODE_PASS8, 10'h001, 10'h001);
		run(ipc_pkg::MODE_YUV, 10'h000, 10'h003);
		run(ipc_pkg::MODE_DYUV, 10'h001, 10'h007);
		for (int i = 0; i < 8; i++) begin
			run(modes[i % 4], 10'(1 + $unsigned($random(seed)) % 6), 10'(1 + $unsigned($random(seed)) % 6));
		end
		check(bm === 1'b0 && csc === 1'b0, "host broke ordering");
		@(posedge clk_sys_in);
		link2.size_wr <= 1'b1;
		@(posedge clk_sys_in);
		link2.size_wr <= 1'b0;
		wr2(ipc_pkg::MODE_NORMAL, 1'b1);
		check(csc2 === 1'b0 && bm2 === 1'b0 && n_store2 == 0, "normal mode flagged or took data");
		wr2(ipc_pkg::MODE_PRE8, 1'b1);
		check(link2.mode_rd === ipc_pkg::MODE_PRE8 && ca2 === 1'b0 && n_store2 == 0, "code 4 took data");
		check(csc2 === 1'b1, "memory select not flagged");
		wr2(ipc_pkg::MODE_BAD5, 1'b0);
		check(bm2 === 1'b1, "forbidden code not flagged");
		// Reset in the middle of a run must leave both devices in normal mode, the first with a zero count and the second with its flags clear.
		cur_mode = ipc_pkg::MODE_PASS16;
		n_feed = 25;
		start(ipc_pkg::MODE_PASS16, 10'h005, 10'h005);
		repeat (12) @(posedge clk_sys_in);
		rst_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(negedge clk_sys_in);
		check(link.mode_rd === ipc_pkg::MODE_NORMAL && pl === ipc_pkg::COUNT_RST, "reset left mode");
		check(link2.mode_rd === ipc_pkg::MODE_NORMAL && bm2 === 1'b0 && csc2 === 1'b0, "reset flags");
		run(ipc_pkg::MODE_PASS16, 10'h002, 10'h003);
		give_verdict();
	end
endmodule : tb_top
